//--- flash_host_pkg.sv
package flash_host_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_ACC_NS      = 70;   // Read access, least
    localparam int T_WP_NS       = 35;   // Write pulse low, least
    localparam int T_WPH_NS      = 20;   // Write pulse high, least
    localparam int T_RP_NS       = 500;  // Reset pulse low, least
    localparam int T_RH_NS       = 50;   // Reset recovery, least
    localparam int SYNC_CYC      = 3;    // Input synchroniser depth

    // Least times round up to whole cycles
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC  = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC  = ACC_CYC + SYNC_CYC;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_CMD    = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    localparam int CTRL_WORD_POS   = 0;
    localparam int CTRL_PROT_POS   = 1;
    localparam int CTRL_ACCEL_POS  = 2;
    localparam int CTRL_BYPASS_POS = 3;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    localparam int STAT_BUSY_POS    = 0;
    localparam int STAT_REFUSED_POS = 1;

    // ----------------------------------------
    // Commands and program sequence
    // ----------------------------------------
    localparam logic [2:0] CMD_READ    = 3'h1;
    localparam logic [2:0] CMD_WRITE   = 3'h2;
    localparam logic [2:0] CMD_PROGRAM = 3'h3;
    localparam logic [2:0] CMD_RESET   = 3'h4;

    localparam logic [1:0]  STEP_FIRST  = 2'h0;
    localparam logic [1:0]  STEP_BYPASS = 2'h2;
    localparam logic [1:0]  STEP_LAST   = 2'h3;
    localparam logic [21:0] UNLOCK_A1   = 22'h000555;
    localparam logic [21:0] UNLOCK_A2   = 22'h0002AA;
    localparam logic [15:0] UNLOCK_D1   = 16'h00AA;
    localparam logic [15:0] UNLOCK_D2   = 16'h0055;
    localparam logic [15:0] PROGRAM_D   = 16'h00A0;

    // ----------------------------------------
    // Controller states
    // ----------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_READ    = 7'h02,
        ST_WR_SET  = 7'h04,
        ST_WR_LOW  = 7'h08,
        ST_WR_HIGH = 7'h10,
        ST_RST_LOW = 7'h20,
        ST_RST_REC = 7'h40
    } ctl_state_e;

endpackage

//--- pin_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
module pin_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] value
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire              agree = (stage2 == stage3);

    // Stage one feeds stage two only, so no logic sees a metastable level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            value  <= '0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (agree)
                value <= stage3;
        end
    end
endmodule

//--- cycle_timer.sv
// Down counter; done while the count stands at zero
module cycle_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    assign done = (count == '0);

    // Load wins over counting so a state can restart its own wait
    always_ff @(posedge clk)
    begin
        if (reset)
            count <= '0;
        else if (load)
            count <= load_value;
        else if (!done)
            count <= count - 1'b1;
    end
endmodule

//--- flash_bus_operation_decode.sv
// The placing of the registers and the strobed register port are this design's own decisions.
module flash_bus_operation_decode (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             flash_chip_select_n,
    output logic             sram_chip_select_one_n,
    output logic             sram_chip_select_two,
    output logic             sram_low_lane_n,
    output logic             sram_high_lane_n,
    output logic             output_enable_n,
    output logic             write_enable_n,
    output logic             hw_reset_n,
    output logic      [21:0] flash_addr,
    output logic             flash_width_select,
    output logic             protect_pin_high,
    output logic             accel_hv_enable,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [15:0] dq_oe
);
    localparam int RD_END  = flash_host_pkg::RD_CYC;
    localparam int WP_END  = flash_host_pkg::WP_CYC;
    localparam int RP_END  = flash_host_pkg::RP_CYC;

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    flash_host_pkg::ctl_state_e state;
    flash_host_pkg::ctl_state_e next_state;
    logic [3:0]  ctrl;
    logic [22:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic        refused;
    logic [1:0]  step;
    logic [1:0]  next_step;
    logic [15:0] dq_sync;
    logic        timer_done;
    logic        timer_load;
    logic [15:0] timer_value;

    // Selects which bus word a sequence step places on the pins
    function automatic logic [21:0] step_addr(input logic [1:0]  s,
                                              input logic [22:0] a);
        unique case (s)
            2'h0:    step_addr = flash_host_pkg::UNLOCK_A1;
            2'h1:    step_addr = flash_host_pkg::UNLOCK_A2;
            2'h2:    step_addr = flash_host_pkg::UNLOCK_A1;
            default: step_addr = a[22:1];
        endcase
    endfunction

    function automatic logic [15:0] step_data(input logic [1:0]  s,
                                              input logic [15:0] d);
        unique case (s)
            2'h0:    step_data = flash_host_pkg::UNLOCK_D1;
            2'h1:    step_data = flash_host_pkg::UNLOCK_D2;
            2'h2:    step_data = flash_host_pkg::PROGRAM_D;
            default: step_data = d;
        endcase
    endfunction

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire       word_mode  = ctrl[flash_host_pkg::CTRL_WORD_POS];
    wire       accel_on   = ctrl[flash_host_pkg::CTRL_ACCEL_POS];
    wire       fast_mode  = ctrl[flash_host_pkg::CTRL_BYPASS_POS] | accel_on;
    wire       busy       = (state != flash_host_pkg::ST_IDLE);
    wire       cmd_wr     = reg_wr && (reg_addr == flash_host_pkg::REG_CMD);
    wire [2:0] cmd_code   = reg_wdata[2:0];
    wire       cmd_take   = cmd_wr && !busy;
    wire       cmd_refuse = cmd_wr && busy;
    wire       stat_clear = reg_wr && (reg_addr == flash_host_pkg::REG_STATUS)
                            && reg_wdata[flash_host_pkg::STAT_REFUSED_POS];
    // Fast mode skips the unlock cycles
    wire [1:0] start_step = (cmd_code == flash_host_pkg::CMD_WRITE)
                            ? flash_host_pkg::STEP_LAST
                            : (fast_mode ? flash_host_pkg::STEP_BYPASS
                                         : flash_host_pkg::STEP_FIRST);
    wire       is_wr_cmd  = (cmd_code == flash_host_pkg::CMD_WRITE)
                            || (cmd_code == flash_host_pkg::CMD_PROGRAM);

    // Control, address and data registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl      <= flash_host_pkg::CTRL_RESET;
            addr_reg  <= '0;
            wdata_reg <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == flash_host_pkg::REG_CTRL)
                ctrl <= reg_wdata[3:0];
            if (reg_addr == flash_host_pkg::REG_ADDR)
                addr_reg <= reg_wdata[22:0];
            if (reg_addr == flash_host_pkg::REG_WDATA)
                wdata_reg <= reg_wdata[15:0];
        end
    end

    // Refused flag; a new refusal wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            refused <= 1'b0;
        else if (cmd_refuse)
            refused <= 1'b1;
        else if (stat_clear)
            refused <= 1'b0;
    end

    // Read data stand in the cycle after the strobe only
    wire [31:0] read_mux =
        (reg_addr == flash_host_pkg::REG_CTRL)   ? {28'h0000000, ctrl} :
        (reg_addr == flash_host_pkg::REG_ADDR)   ? {9'h000, addr_reg} :
        (reg_addr == flash_host_pkg::REG_WDATA)  ? {16'h0000, wdata_reg} :
        (reg_addr == flash_host_pkg::REG_RDATA)  ? {16'h0000, rdata_reg} :
        (reg_addr == flash_host_pkg::REG_STATUS) ? {30'h00000000, refused, busy}
                                                 : 32'h00000000;

    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? read_mux : 32'h00000000;
    end

    // ----------------------------------------
    // Bus sequencer
    // ----------------------------------------
    pin_sync #(.WIDTH(16)) u_sync (
        .clk   (clk),
        .reset (reset),
        .pin   (dq_in),
        .value (dq_sync)
    );

    cycle_timer #(.WIDTH(16)) u_timer (
        .clk        (clk),
        .reset      (reset),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    // Next state and wait length; every wait loads count minus one
    always_comb
    begin
        next_state  = state;
        next_step   = step;
        timer_load  = 1'b0;
        timer_value = 16'h0000;
        unique case (state)
            flash_host_pkg::ST_IDLE:
                if (cmd_take && cmd_code == flash_host_pkg::CMD_READ)
                begin
                    next_state  = flash_host_pkg::ST_READ;
                    timer_load  = 1'b1;
                    timer_value = 16'(flash_host_pkg::RD_CYC - 1);
                end
                else if (cmd_take && is_wr_cmd)
                begin
                    next_state = flash_host_pkg::ST_WR_SET;
                    next_step  = start_step;
                end
                else if (cmd_take && cmd_code == flash_host_pkg::CMD_RESET)
                begin
                    next_state  = flash_host_pkg::ST_RST_LOW;
                    timer_load  = 1'b1;
                    timer_value = 16'(flash_host_pkg::RP_CYC - 1);
                end
            flash_host_pkg::ST_READ:
                if (timer_done)
                    next_state = flash_host_pkg::ST_IDLE;
            flash_host_pkg::ST_WR_SET:
            begin
                next_state  = flash_host_pkg::ST_WR_LOW;
                timer_load  = 1'b1;
                timer_value = 16'(flash_host_pkg::WP_CYC - 1);
            end
            flash_host_pkg::ST_WR_LOW:
                if (timer_done)
                begin
                    next_state  = flash_host_pkg::ST_WR_HIGH;
                    timer_load  = 1'b1;
                    timer_value = 16'(flash_host_pkg::WPH_CYC - 1);
                end
            flash_host_pkg::ST_WR_HIGH:
                if (timer_done && step == flash_host_pkg::STEP_LAST)
                    next_state = flash_host_pkg::ST_IDLE;
                else if (timer_done)
                begin
                    next_state = flash_host_pkg::ST_WR_SET;
                    next_step  = step + 2'h1;
                end
            flash_host_pkg::ST_RST_LOW:
                if (timer_done)
                begin
                    next_state  = flash_host_pkg::ST_RST_REC;
                    timer_load  = 1'b1;
                    timer_value = 16'(flash_host_pkg::RH_CYC - 1);
                end
            flash_host_pkg::ST_RST_REC:
                if (timer_done)
                    next_state = flash_host_pkg::ST_IDLE;
            default:
                next_state = flash_host_pkg::ST_IDLE;
        endcase
    end

    // Pin levels decoded from the next state so they align with it
    wire in_read = (next_state == flash_host_pkg::ST_READ);
    wire in_wr   = (next_state == flash_host_pkg::ST_WR_SET)
                   || (next_state == flash_host_pkg::ST_WR_LOW)
                   || (next_state == flash_host_pkg::ST_WR_HIGH);
    wire in_rst  = (next_state == flash_host_pkg::ST_RST_LOW);
    wire we_low  = (next_state == flash_host_pkg::ST_WR_LOW);
    wire [21:0] next_addr = in_wr ? step_addr(next_step, addr_reg)
                                  : addr_reg[22:1];
    wire [15:0] wr_word   = step_data(next_step, wdata_reg);
    // Byte width: pin 15 carries the lowest address bit, 14..8 float
    wire        low_bit   = in_wr && next_step != flash_host_pkg::STEP_LAST
                            ? 1'b0 : addr_reg[0];
    wire [15:0] next_dq   = word_mode ? wr_word
                                      : {low_bit, 7'h00, wr_word[7:0]};
    wire [15:0] next_oe   = word_mode ? {16{in_wr}}
                                      : {in_read | in_wr, 7'h00,
                                         {8{in_wr}}};

    // State and registered pins
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state               <= flash_host_pkg::ST_IDLE;
            step                <= flash_host_pkg::STEP_FIRST;
            flash_chip_select_n <= 1'b1;
            output_enable_n     <= 1'b1;
            write_enable_n      <= 1'b1;
            hw_reset_n          <= 1'b0;
            flash_addr          <= '0;
            dq_out              <= '0;
            dq_oe               <= '0;
        end
        else
        begin
            state               <= next_state;
            step                <= next_step;
            flash_chip_select_n <= !(in_read || in_wr);
            output_enable_n     <= !in_read;
            write_enable_n      <= !we_low;
            hw_reset_n          <= !in_rst;
            flash_addr          <= next_addr;
            dq_out              <= next_dq;
            dq_oe               <= next_oe;
        end
    end

    // Capture read data once access time and synchroniser have passed
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_reg <= '0;
        else if (state == flash_host_pkg::ST_READ && timer_done)
            rdata_reg <= word_mode ? dq_sync : {8'h00, dq_sync[7:0]};
    end

    // ----------------------------------------
    // Static pins and high voltage enable
    // ----------------------------------------
    // RAM stays deselected; lanes held high rather than left open
    assign sram_chip_select_one_n = 1'b1;
    assign sram_chip_select_two   = 1'b0;
    assign sram_low_lane_n        = 1'b1;
    assign sram_high_lane_n       = 1'b1;
    assign flash_width_select     = word_mode;
    assign protect_pin_high       = ctrl[flash_host_pkg::CTRL_PROT_POS];
    // High voltage only while accel is set and a program or write command is running
    assign accel_hv_enable = accel_on && in_wr == 1'b0 ? 1'b0
                             : accel_on && step >= flash_host_pkg::STEP_BYPASS
                               && state != flash_host_pkg::ST_IDLE
                               && state != flash_host_pkg::ST_READ
                               && state != flash_host_pkg::ST_RST_LOW
                               && state != flash_host_pkg::ST_RST_REC;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_we_pulse;
        $fell(write_enable_n) ##WP_END $rose(write_enable_n);
    endsequence

    property p_no_dual_select;
        !flash_chip_select_n |-> sram_chip_select_one_n
                                 && !sram_chip_select_two;
    endproperty
    a_no_dual_select: assert property (p_no_dual_select)
        else $error("flash and ram selected together");

    property p_read_pins;
        !output_enable_n |-> !flash_chip_select_n && write_enable_n;
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("read pins wrong");

    property p_write_pins;
        !write_enable_n |-> !flash_chip_select_n && output_enable_n
                            && (|dq_oe);
    endproperty
    a_write_pins: assert property (p_write_pins)
        else $error("write pins wrong");

    property p_read_length;
        $fell(output_enable_n) |-> ##RD_END $rose(output_enable_n);
    endproperty
    a_read_length: assert property (p_read_length)
        else $error("read cycle length wrong");

    property p_write_pulse;
        // High phase spans four cycles, plus setup before any next step
        $fell(write_enable_n) |-> s_we_pulse ##1 write_enable_n[*4];
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("write pulse length wrong");

    property p_byte_lanes;
        !flash_width_select |-> dq_oe[14:8] == 7'h00;
    endproperty
    a_byte_lanes: assert property (p_byte_lanes)
        else $error("upper lanes driven in byte width");

    property p_no_contention;
        !output_enable_n |-> dq_oe[7:0] == 8'h00;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data while device outputs");

    property p_reset_pulse;
        $fell(hw_reset_n) |-> (flash_chip_select_n && output_enable_n)
                              throughout (##RP_END $rose(hw_reset_n));
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("reset pulse wrong");

    property p_fast_program;
        cmd_take && cmd_code == flash_host_pkg::CMD_PROGRAM && fast_mode
        |=> step == flash_host_pkg::STEP_BYPASS;
    endproperty
    a_fast_program: assert property (p_fast_program)
        else $error("fast program did not skip unlock");

    property p_refuse;
        cmd_refuse |=> refused;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("busy command not flagged");
endmodule

//--- flash_model.sv
module flash_model (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rst_n,
    input  wire logic        width,
    input  wire logic        hv,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] host_d,
    input  wire logic [15:0] host_oe,
    output logic      [15:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0000;
    logic [15:0] wr_d = 16'h0000;
    int          n_wr = 0;
    int          n_hv = 0;
    int          n_rst = 0;
    // Array read only; no command ever leaves array mode here
    wire         rd_en = !ce_n && !oe_n && we_n && rst_n;
    wire  [15:0] arr = {addr[7:0], ~addr[7:0]};
    wire  [7:0]  byt = host_d[15] ? arr[15:8] : arr[7:0];
    wire  [15:0] dev = width ? arr : {~arr[15:8], byt};
    // Floating lines outside a read hold the inverse of the last value read
    assign dq = (host_oe & host_d) | (~host_oe & (rd_en ? dev : ~last));
    always @(dev or rd_en)
        if (rd_en)
            last = dev;
    // Reset pulses counted as they end; power-up release counts once
    always @(posedge rst_n)
        n_rst = n_rst + 1;
    // Write pulses counted at the rising write enable
    always @(posedge we_n)
        if (!ce_n && oe_n && rst_n)
        begin
            n_wr = n_wr + 1;
            wr_d = dq;
            if (hv)
                n_hv = n_hv + 1;
        end
endmodule

//--- tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, seen;
    logic        flash_chip_select_n, output_enable_n, write_enable_n;
    logic        hw_reset_n, flash_width_select, protect_pin_high;
    logic        accel_hv_enable, sram1_n, sram2, lo_n, hi_n;
    logic [21:0] flash_addr;
    logic [15:0] dq_in, dq_out, dq_oe;
    int          fails = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          base;
    initial forever #2.5 clk = ~clk;
    flash_bus_operation_decode u_dut (.clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .flash_chip_select_n,
        .sram_chip_select_one_n(sram1_n), .sram_chip_select_two(sram2),
        .sram_low_lane_n(lo_n), .sram_high_lane_n(hi_n), .output_enable_n,
        .write_enable_n, .hw_reset_n, .flash_addr, .flash_width_select,
        .protect_pin_high, .accel_hv_enable, .dq_in, .dq_out, .dq_oe);
    flash_model u_flash (.ce_n(flash_chip_select_n), .oe_n(output_enable_n),
        .we_n(write_enable_n), .rst_n(hw_reset_n), .width(flash_width_select),
        .hv(accel_hv_enable), .addr(flash_addr), .host_d(dq_out),
        .host_oe(dq_oe), .dq(dq_in));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        seen = reg_rdata;
    endtask
    task automatic idle();
        for (int i = 0; i < 100; i++)
        begin
            rd(flash_host_pkg::REG_STATUS);
            if (seen[0] === 1'b0)
                break;
        end
        chk(seen & 32'h1, 32'h0);
    endtask
    // Command, then the count of write pulses it produced
    task automatic cmd(input logic [2:0] c, input int n);
        base = u_flash.n_wr;
        wr(flash_host_pkg::REG_CMD, {29'h0, c});
        idle();
        chk(32'(u_flash.n_wr - base), 32'(n));
    endtask
    task automatic conclude();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            conclude();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(flash_host_pkg::REG_CTRL);
        chk(seen, 32'h1);
        rd(8'h20);
        chk(seen, 32'h0);
        chk({28'h0, sram1_n, sram2, lo_n, hi_n}, 32'hB);
        wr(flash_host_pkg::REG_ADDR, 32'h0000_0010);
        cmd(flash_host_pkg::CMD_READ, 0);
        rd(flash_host_pkg::REG_RDATA);
        chk(seen, 32'h0000_08F7);
        $display("word read done");
        wr(flash_host_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            wr(flash_host_pkg::REG_ADDR, 32'h10 + i);
            cmd(flash_host_pkg::CMD_READ, 0);
            rd(flash_host_pkg::REG_RDATA);
            chk(seen, (i == 1) ? 32'h08 : 32'hF7);
        end
        wr(flash_host_pkg::REG_WDATA, 32'h1234);
        cmd(flash_host_pkg::CMD_WRITE, 1);
        chk({24'h0, u_flash.wr_d[7:0]}, 32'h34);
        $display("byte mode done");
        wr(flash_host_pkg::REG_CTRL, 32'h1);
        cmd(flash_host_pkg::CMD_PROGRAM, 4);
        chk({16'h0, u_flash.wr_d}, 32'h1234);
        wr(flash_host_pkg::REG_CTRL, 32'h9);
        cmd(flash_host_pkg::CMD_PROGRAM, 2);
        wr(flash_host_pkg::REG_CTRL, 32'h5);
        cmd(flash_host_pkg::CMD_PROGRAM, 2);
        chk(32'(u_flash.n_hv), 32'h2);
        wr(flash_host_pkg::REG_CTRL, 32'h3);
        cmd(flash_host_pkg::CMD_PROGRAM, 4);
        chk({31'h0, protect_pin_high}, 32'h1);
        $display("program done");
        wr(flash_host_pkg::REG_CMD, 32'h1);
        wr(flash_host_pkg::REG_CMD, 32'h1);
        idle();
        rd(flash_host_pkg::REG_STATUS);
        chk(seen, 32'h2);
        wr(flash_host_pkg::REG_STATUS, 32'h2);
        rd(flash_host_pkg::REG_STATUS);
        chk(seen, 32'h0);
        cmd(flash_host_pkg::CMD_RESET, 0);
        chk(32'(u_flash.n_rst), 32'h2);
        cmd(flash_host_pkg::CMD_READ, 0);
        rd(flash_host_pkg::REG_RDATA);
        chk(seen, 32'h0000_08F7);
        $display("refusal and reset done");
        conclude();
    end
endmodule
